// >>> bank_check_assertions.sv
// Checker for the synthesizer control bank
`timescale 1ns/10ps
`include "synth_ctrl_map.vh"
module bank_check (
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  input wire spi_le,
  input wire lock_detect,
  input wire monitor_output_pin,
  input wire [10:0] divider_denominator,
  input wire [10:0] fractional_numerator,
  input wire [2:0] pump_current_multiplier,
  input wire [3:0] monitor_select,
  input wire [4:0] vco_amplitude,
  input wire tuning_range_calibration
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence le_idle;
    (!spi_le) [*8];
  endsequence
  sequence mon_steady;
    !$past(reset) && monitor_select == `MON_LOCK_DETECT && $past(monitor_select) == `MON_LOCK_DETECT;
  endsequence
  a_cal_single: assert property (tuning_range_calibration |=> !tuning_range_calibration)
    else $error("calibration pulse longer than one cycle");
  a_cal_cause: assert property (tuning_range_calibration |-> $past(spi_le, 3))
    else $error("calibration pulse without a latched word");
  a_den_cal: assert property (!$stable(divider_denominator) |-> tuning_range_calibration)
    else $error("denominator changed without calibration");
  a_num_cal: assert property (!$stable(fractional_numerator) |-> tuning_range_calibration)
    else $error("numerator changed without calibration");
  a_field_hold: assert property (le_idle |-> $stable(divider_denominator) && $stable(vco_amplitude))
    else $error("field changed with no word latched");
  a_mult_range: assert property (pump_current_multiplier inside {[3'h1:3'h4]})
    else $error("pump multiplier out of range");
  a_mon_lock: assert property (mon_steady |-> monitor_output_pin == $past(lock_detect))
    else $error("monitor pin does not follow lock detect");
  a_reset_dflt: assert property (disable iff (1'b0) reset && clk_en |=> divider_denominator == `DENOM_RESET
    && fractional_numerator == `NUMER_RESET && vco_amplitude == `VCO_AMP_RESET)
    else $error("reset defaults wrong");
endmodule // bank_check
bind synth_control_register_bank bank_check u_chk (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
  .spi_le(spi_le), .lock_detect(lock_detect), .monitor_output_pin(monitor_output_pin),
  .divider_denominator(divider_denominator), .fractional_numerator(fractional_numerator),
  .pump_current_multiplier(pump_current_multiplier), .monitor_select(monitor_select),
  .vco_amplitude(vco_amplitude), .tuning_range_calibration(tuning_range_calibration));

// >>> serial_host.sv
// Serial host model that shifts control words into the bank
`timescale 1ns/10ps
module serial_host (
  input wire clk_sys,
  output reg spi_clk,
  output reg spi_data,
  output reg spi_le
);
  initial begin
    spi_clk = 1'b0;
    spi_data = 1'b0;
    spi_le = 1'b0;
  end
  task hold;
    begin
      repeat (5) @(posedge clk_sys);
      #1;
    end
  endtask
  // MSB first, select code in the last three bits
  task send(input [31:0] w, input integer n);
    integer i;
    begin
      for (i = n - 1; i >= 0; i = i - 1) begin
        spi_data = w[i];
        hold;
        spi_clk = 1'b1;
        hold;
        spi_clk = 1'b0;
      end
      spi_data = ~spi_data;
      spi_le = 1'b1;
      hold;
      spi_le = 1'b0;
      hold;
      hold;
    end
  endtask
endmodule // serial_host

// >>> synth_control_register_bank.v
// Serially loaded control register bank for the synthesizer and demodulator
// Functional notes
// RULE1: Word with select 001 writes the denominator register.
// RULE2: Host keeps denominator within 1 to 2047.
// RULE3: Denominator in bits 13..3, upper bits zero, default 1536.
// RULE4: Word with select 010 writes the numerator register.
// RULE5: Host keeps numerator below the programmed denominator.
// RULE6: Numerator in bits 13..3, upper bits zero, default 768.
// RULE7: Word with select 011 writes the dither control register.
// RULE8: Dither restart accepts 0 to 2^17-1; 1 recommended.
// RULE9: Word with select 100 writes the charge pump and reference register.
// RULE10: Bit 18 picks internal or external base current resistor.
// RULE11: Pump current multiplier is one plus bits 11..10.
// RULE12: Bits 16..12 hold the phase offset multiplier.
// RULE13: Bit 17 sets phase offset sign.
// RULE14: Reference scaling choices: double, unity, half, quarter.
// RULE15: Monitor pin shows selected signal, lock detect by default.
// RULE16: LO path register sets LO pin direction and demodulator bias.
// RULE17: LO path register sets pre-divider to one or two.
// RULE18: Word with select 110 writes the VCO control register.
// RULE19: Band source picks calibration or serial band select.
// RULE20: VCO amplitude 0 to 31, default 24.
// RULE21: Separate VCO and regulator disables.
// RULE22: Charge pump enable, normally set.
// RULE23: Any integer, denominator or numerator write starts band calibration.
// RULE24: Host writes descending from 7, VCO register before frequency.
// RULE25: Unknown select codes are ignored.
// RULE26: Registers load the whole word only after the full word latches.
`timescale 1ns/10ps
`include "synth_ctrl_map.vh"
module synth_control_register_bank (
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  input wire spi_clk,
  input wire spi_data,
  input wire spi_le,
  input wire lock_detect,
  input wire temp_monitor,
  input wire ref_clk_monitor,
  input wire div_clk_monitor,
  output reg monitor_output_pin,
  output reg [15:0] integer_word,
  output reg [10:0] divider_denominator,
  output reg [10:0] fractional_numerator,
  output reg [16:0] dither_restart,
  output reg ext_rset_select,
  output reg phase_offset_negative,
  output reg [4:0] phase_offset_multiplier,
  output reg [2:0] pump_current_multiplier,
  output reg [1:0] ref_scale_select,
  output reg [3:0] monitor_select,
  output reg lo_pins_output,
  output reg lo_prediv_by_two,
  output reg demod_bias_enable,
  output reg band_select_source,
  output reg [6:0] vco_band_select,
  output reg [4:0] vco_amplitude,
  output reg vco_enable,
  output reg vco_ldo_enable,
  output reg charge_pump_enable,
  output reg tuning_range_calibration
);
  // Pin synchronisers: three stages, second and third compared
  reg [2:0] sclk_sync_reg;
  reg [2:0] sdata_sync_reg;
  reg [2:0] le_sync_reg;
  reg sclk_state_reg;
  reg le_state_reg;
  reg data_state_reg;
  reg [`WORD_BITS-1:0] shift_reg;
  reg [`WORD_BITS-1:0] latched_reg;
  reg latch_pending_reg;
  reg store_wr_reg;
  wire [`WORD_BITS-1:0] store_rd_word;
  wire sclk_rise;
  wire le_rise;
  wire [2:0] sel;
  wire sel_valid;

  always @(posedge clk_sys) begin
    if (reset) begin
      sclk_sync_reg <= 3'h0;
      sdata_sync_reg <= 3'h0;
      le_sync_reg <= 3'h0;
    end else if (clk_en) begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], spi_clk};
      sdata_sync_reg <= {sdata_sync_reg[1:0], spi_data};
      le_sync_reg <= {le_sync_reg[1:0], spi_le};
    end
  end

  // Filtered pin levels change only when stages two and three agree
  always @(posedge clk_sys) begin
    if (reset) begin
      sclk_state_reg <= 1'b0;
      le_state_reg <= 1'b0;
      data_state_reg <= 1'b0;
    end else if (clk_en) begin
      if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
        sclk_state_reg <= sclk_sync_reg[2];
      end
      if (le_sync_reg[1] == le_sync_reg[2]) begin
        le_state_reg <= le_sync_reg[2];
      end
      if (sdata_sync_reg[1] == sdata_sync_reg[2]) begin
        data_state_reg <= sdata_sync_reg[2];
      end
    end
  end

  assign sclk_rise = (sclk_sync_reg[1] == sclk_sync_reg[2]) && sclk_sync_reg[2] && !sclk_state_reg;
  assign le_rise = (le_sync_reg[1] == le_sync_reg[2]) && le_sync_reg[2] && !le_state_reg;

  // Shift in MSB first; the word is held until load enable rises
  always @(posedge clk_sys) begin
    if (reset) begin
      shift_reg <= 24'h000000;
      latched_reg <= 24'h000000;
      latch_pending_reg <= 1'b0;
    end else if (clk_en) begin
      if (sclk_rise) begin
        shift_reg <= {shift_reg[`WORD_BITS-2:0], data_state_reg};
      end
      latch_pending_reg <= le_rise; // RULE26
      if (le_rise) begin
        latched_reg <= shift_reg; // RULE26
      end
    end
  end

  assign sel = latched_reg[`SEL_MSB:0];
  assign sel_valid = (sel != 3'h7); // RULE25

  // Copy of every accepted word; the denominator entry is read back for monitor select code 4
  always @(posedge clk_sys) begin
    if (reset) begin
      store_wr_reg <= 1'b0;
    end else if (clk_en) begin
      store_wr_reg <= latch_pending_reg && sel_valid;
    end
  end

  word_store u_store (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .wr_en(latch_pending_reg && sel_valid),
    .wr_index(sel),
    .wr_word(latched_reg),
    .rd_index(`SEL_DENOM),
    .rd_word(store_rd_word)
  );

  // Field decode on the cycle after a complete word is latched
  always @(posedge clk_sys) begin
    if (reset) begin
      integer_word <= 16'h0000;
      divider_denominator <= `DENOM_RESET; // RULE3
      fractional_numerator <= `NUMER_RESET; // RULE6
      dither_restart <= `DITHER_RESET;
      ext_rset_select <= 1'b0;
      phase_offset_negative <= 1'b0;
      phase_offset_multiplier <= 5'h00;
      pump_current_multiplier <= 3'h1;
      ref_scale_select <= 2'h1;
      monitor_select <= `MON_LOCK_DETECT; // RULE15
      lo_pins_output <= 1'b0;
      lo_prediv_by_two <= 1'b1;
      demod_bias_enable <= 1'b1;
      band_select_source <= 1'b0;
      vco_band_select <= 7'h00;
      vco_amplitude <= `VCO_AMP_RESET; // RULE20
      vco_enable <= 1'b1;
      vco_ldo_enable <= 1'b1;
      charge_pump_enable <= 1'b1; // RULE22
      tuning_range_calibration <= 1'b0;
    end else if (clk_en) begin
      tuning_range_calibration <= 1'b0;
      if (latch_pending_reg) begin
        if (sel == `SEL_INTEGER) begin
          integer_word <= latched_reg[18:3];
          tuning_range_calibration <= 1'b1; // RULE23
        end else if (sel == `SEL_DENOM) begin
          divider_denominator <= latched_reg[`FRAC_MSB:`FRAC_LSB]; // RULE1 RULE3
          tuning_range_calibration <= 1'b1; // RULE23
        end else if (sel == `SEL_NUMER) begin
          fractional_numerator <= latched_reg[`FRAC_MSB:`FRAC_LSB]; // RULE4 RULE6
          tuning_range_calibration <= 1'b1; // RULE23
        end else if (sel == `SEL_DITHER) begin
          dither_restart <= latched_reg[`DITHER_MSB:`FRAC_LSB]; // RULE7
        end else if (sel == `SEL_PUMP) begin
          ext_rset_select <= latched_reg[`PUMP_EXT_RSET_BIT]; // RULE9 RULE10
          phase_offset_negative <= latched_reg[`PUMP_OFS_SIGN_BIT]; // RULE13
          phase_offset_multiplier <= latched_reg[`PUMP_OFS_MSB:`PUMP_OFS_LSB]; // RULE12
          pump_current_multiplier <= {1'b0, latched_reg[`PUMP_MULT_MSB:`PUMP_MULT_LSB]} + 3'h1; // RULE11
          ref_scale_select <= latched_reg[`PUMP_REFSCALE_MSB:`PUMP_REFSCALE_LSB]; // RULE14
          monitor_select <= latched_reg[`PUMP_MON_MSB:`PUMP_MON_LSB]; // RULE15
        end else if (sel == `SEL_LOPATH) begin
          lo_pins_output <= latched_reg[`LO_OUT_BIT]; // RULE16
          demod_bias_enable <= latched_reg[`LO_BIAS_BIT]; // RULE16
          lo_prediv_by_two <= latched_reg[`LO_DIV_BIT]; // RULE17
        end else if (sel == `SEL_VCO) begin
          vco_ldo_enable <= latched_reg[`VCO_LDO_EN_BIT]; // RULE18 RULE21
          vco_enable <= latched_reg[`VCO_EN_BIT]; // RULE21
          charge_pump_enable <= latched_reg[`VCO_CP_EN_BIT]; // RULE22
          band_select_source <= latched_reg[`BAND_SELECT_SOURCE_BIT]; // RULE19
          vco_amplitude <= latched_reg[`VCO_AMP_MSB:`VCO_AMP_LSB]; // RULE20
          vco_band_select <= latched_reg[`VCO_BAND_MSB:`VCO_BAND_LSB]; // RULE19
        end
      end
    end
  end

  // Monitor pin mux; code 0 is lock detect
  always @(posedge clk_sys) begin
    if (reset) begin
      monitor_output_pin <= 1'b0;
    end else if (clk_en) begin
      if (monitor_select == 4'h1) begin
        monitor_output_pin <= temp_monitor; // RULE15
      end else if (monitor_select == 4'h2) begin
        monitor_output_pin <= ref_clk_monitor;
      end else if (monitor_select == 4'h3) begin
        monitor_output_pin <= div_clk_monitor;
      end else if (monitor_select == 4'h4) begin
        monitor_output_pin <= store_rd_word[`FRAC_MSB] & store_wr_reg;
      end else begin
        monitor_output_pin <= lock_detect; // RULE15
      end
    end
  end
endmodule // synth_control_register_bank

// >>> synth_control_register_bank_tb.sv
// Self-checking bench for the synthesizer control bank
`timescale 1ns/10ps
module synth_control_register_bank_tb;
  reg clk_sys;
  reg reset;
  reg [3:0] mon_in;
  reg [3:0] mon_prev;
  reg [31:0] rng;
  reg [31:0] r;
  reg [23:0] w;
  integer m [0:7];
  integer error_cnt, n_checks, cal_cnt, i, s;
  wire spi_clk, spi_data, spi_le, mon_pin, cal;
  wire [89:0] got;
  serial_host host (.clk_sys(clk_sys), .spi_clk(spi_clk), .spi_data(spi_data), .spi_le(spi_le));
  synth_control_register_bank dut (.clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .spi_clk(spi_clk),
    .spi_data(spi_data), .spi_le(spi_le), .lock_detect(mon_in[0]), .temp_monitor(mon_in[1]),
    .ref_clk_monitor(mon_in[2]), .div_clk_monitor(mon_in[3]), .monitor_output_pin(mon_pin),
    .integer_word(got[89:74]), .divider_denominator(got[73:63]), .fractional_numerator(got[62:52]),
    .dither_restart(got[51:35]), .ext_rset_select(got[34]), .phase_offset_negative(got[33]),
    .phase_offset_multiplier(got[32:28]), .pump_current_multiplier(got[27:25]),
    .ref_scale_select(got[24:23]), .monitor_select(got[22:19]), .lo_pins_output(got[18]),
    .lo_prediv_by_two(got[17]), .demod_bias_enable(got[16]), .band_select_source(got[15]),
    .vco_band_select(got[14:8]), .vco_amplitude(got[7:3]), .vco_enable(got[2]), .vco_ldo_enable(got[1]),
    .charge_pump_enable(got[0]), .tuning_range_calibration(cal));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (cal === 1'b1) cal_cnt <= cal_cnt + 1;
    #1 mon_in = (mon_in + 4'h7) ^ rng[3:0];
  end
  // Source levels seen by the monitor register at the last edge
  always @(posedge clk_sys) mon_prev <= mon_in;
  function automatic exp_mon(input [3:0] c);
    begin
      if (c == 4'h1) exp_mon = mon_prev[1];
      else if (c == 4'h2) exp_mon = mon_prev[2];
      else if (c == 4'h3) exp_mon = mon_prev[3];
      else if (c == 4'h4) exp_mon = 1'b0;
      else exp_mon = mon_prev[0];
    end
  endfunction
  task check_mon(input e, input g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("wrong value monitor pin exp %b got %b", e, g);
      end
    end
  endtask
  function automatic [31:0] xs();
    reg [31:0] x;
    x = rng;
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    rng = x;
    xs = x;
  endfunction
  function automatic [89:0] expv();
    expv = {m[0][18:3], m[1][13:3], m[2][13:3], m[3][19:3], m[4][18:12], {1'b0, m[4][11:10]} + 3'h1,
      m[4][9:4], m[5][4], m[5][3], m[5][7], m[6][15], m[6][9:3], m[6][14:10], m[6][17], m[6][18], m[6][16]};
  endfunction
  task model_reset;
    begin
      m[0] = 24'h000000;
      m[1] = 24'h003001;
      m[2] = 24'h001802;
      m[3] = 24'h00000B;
      m[4] = 24'h000104;
      m[5] = 24'h00008D;
      m[6] = 24'h076006;
      m[7] = 24'h000000;
    end
  endtask
  task check_vec(input [89:0] e, input [89:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("wrong value fields exp %h got %h", e, g);
      end
    end
  endtask
  task check_cnt(input integer e, input integer g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("wrong value calibration pulses exp %0d got %0d", e, g);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #5000000;
    error_cnt = error_cnt + 1;
    finish_test;
  end
  initial begin
    rng = 63617;
    reset = 1'b1;
    mon_in = 4'h0;
    error_cnt = 0;
    n_checks = 0;
    cal_cnt = 0;
    model_reset;
    repeat (4) @(posedge clk_sys);
    #1 reset = 1'b0;
    check_vec(expv(), got);
    for (i = 0; i < 40; i = i + 1) begin
      s = 7 - (i % 8);
      r = xs();
      w = {r[23:3], s[2:0]};
      if (s == 1 || s == 2) w[23:14] = 10'h000;
      if (s == 1 && w[13:3] == 11'h000) w[3] = 1'b1;
      if (i == 6) w[13:3] = 11'h7FF;
      if (i == 14) w[13:3] = 11'h001;
      if (i == 22) w = m[1];
      if (s == 2) w[13:3] = r[31:8] % m[1][13:3];
      if (s == 3) w[23:20] = 4'h0;
      cal_cnt = 0;
      host.send({r[31:24], w}, (i == 12) ? 28 : 24);
      if (s != 7) m[s] = w;
      check_cnt((s < 3) ? 1 : 0, cal_cnt);
      check_vec(expv(), got);
      #1 check_mon(exp_mon(m[4][7:4]), mon_pin);
    end
    reset = 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 reset = 1'b0;
    model_reset;
    check_vec(expv(), got);
    finish_test;
  end
endmodule // synth_control_register_bank_tb

// >>> synth_ctrl_map.vh
// Register select codes, field positions and reset values for the synthesizer control bank
`ifndef SYNTH_CTRL_MAP_VH
`define SYNTH_CTRL_MAP_VH
`define SEL_INTEGER 3'h0
`define SEL_DENOM 3'h1
`define SEL_NUMER 3'h2
`define SEL_DITHER 3'h3
`define SEL_PUMP 3'h4
`define SEL_LOPATH 3'h5
`define SEL_VCO 3'h6
`define WORD_BITS 24
`define SEL_MSB 2
`define FRAC_MSB 13
`define FRAC_LSB 3
`define DENOM_RESET 11'h600
`define NUMER_RESET 11'h300
`define DITHER_RESET 17'h00001
`define DITHER_MSB 19
`define PUMP_EXT_RSET_BIT 18
`define PUMP_OFS_SIGN_BIT 17
`define PUMP_OFS_MSB 16
`define PUMP_OFS_LSB 12
`define PUMP_MULT_MSB 11
`define PUMP_MULT_LSB 10
`define PUMP_REFSCALE_MSB 9
`define PUMP_REFSCALE_LSB 8
`define PUMP_MON_MSB 7
`define PUMP_MON_LSB 4
`define MON_LOCK_DETECT 4'h0
`define PUMP_RESET 24'h000004
`define LO_DIV_BIT 3
`define LO_OUT_BIT 4
`define LO_BIAS_BIT 7
`define LO_RESET 24'h000085
`define VCO_LDO_EN_BIT 18
`define VCO_EN_BIT 17
`define VCO_CP_EN_BIT 16
`define BAND_SELECT_SOURCE_BIT 15
`define VCO_AMP_MSB 14
`define VCO_AMP_LSB 10
`define VCO_BAND_MSB 9
`define VCO_BAND_LSB 3
`define VCO_AMP_RESET 5'h18
`define VCO_RESET 24'h076006
`define LATCH_INDEX_BITS 3
`endif

// >>> word_store.v
// Small register store holding the latched words, one entry per select code
`timescale 1ns/10ps
`include "synth_ctrl_map.vh"
module word_store (
  input wire clk_sys,
  input wire reset,
  input wire clk_en,
  input wire wr_en,
  input wire [`LATCH_INDEX_BITS-1:0] wr_index,
  input wire [`WORD_BITS-1:0] wr_word,
  input wire [`LATCH_INDEX_BITS-1:0] rd_index,
  output reg [`WORD_BITS-1:0] rd_word
);
  reg [`WORD_BITS-1:0] mem_reg [0:7];
  integer i;
  always @(posedge clk_sys) begin
    if (reset) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem_reg[i] <= 24'h000000;
      end
      mem_reg[1] <= {10'h000, `DENOM_RESET, `SEL_DENOM};
      mem_reg[2] <= {10'h000, `NUMER_RESET, `SEL_NUMER};
      mem_reg[3] <= {4'h0, `DITHER_RESET, `SEL_DITHER};
      mem_reg[4] <= `PUMP_RESET;
      mem_reg[5] <= `LO_RESET;
      mem_reg[6] <= `VCO_RESET;
      rd_word <= 24'h000000;
    end else if (clk_en) begin
      if (wr_en) begin
        mem_reg[wr_index] <= wr_word;
      end
      rd_word <= mem_reg[rd_index];
    end
  end
endmodule // word_store
